// ---- design/papc_pkg.sv ----
// package: register map, field positions, timing and carriers for the alert pulse block
package papc_pkg;
	localparam logic [15:0] PAPC_TRIG_ADDR      = 16'h0053;
	localparam logic [15:0] PAPC_PRESSURE_CHANGE_CONFIG_ADDR     = 16'h0054;
	localparam logic [15:0] PAPC_STATUS_ADDR    = 16'h0055;
	localparam logic [7:0]  PAPC_TRIG_RESET     = 8'h3E;
	localparam logic [7:0]  PAPC_PRESSURE_CHANGE_CONFIG_RESET    = 8'h01;
	localparam logic [7:0]  PAPC_STATUS_RESET   = 8'h00;
	localparam logic [7:0]  PAPC_TRIG_WMASK     = 8'h3F;
	localparam logic [7:0]  PAPC_PRESSURE_CHANGE_CONFIG_WMASK    = 8'h07;
	localparam int          PAPC_POL_BIT        = 5;
	localparam int          PAPC_DUR_BIT        = 4;
	localparam int          PAPC_FV_BIT         = 3;
	localparam int          PAPC_ST_BIT         = 2;
	localparam int          PAPC_ACQERR_BIT     = 1;
	localparam int          PAPC_RDY_BIT        = 0;
	localparam int          PAPC_SLOPE_EN_BIT   = 2;
	localparam int          PAPC_REL_EN_BIT     = 1;
	localparam int          PAPC_FIX_EN_BIT     = 0;
	localparam int          PAPC_SUM_F_BIT      = 7;
	localparam int          PAPC_SLOPE_F_BIT    = 6;
	localparam int          PAPC_REL_F_BIT      = 5;
	localparam int          PAPC_FIX_F_BIT      = 4;
	localparam int          PAPC_FW_F_BIT       = 3;
	localparam int          PAPC_CELL_F_BIT     = 2;
	localparam int          PAPC_CONV_F_BIT     = 1;
	localparam int          PAPC_ACQ_F_BIT      = 0;
	localparam int          PAPC_CLK_HZ         = 100_000_000;
	localparam int          PAPC_SHORT_MS       = 4;
	localparam int          PAPC_LONG_MS        = 8;
	localparam int          PAPC_SHORT_CYC      = PAPC_CLK_HZ / 1000 * PAPC_SHORT_MS;
	localparam int          PAPC_LONG_CYC       = PAPC_CLK_HZ / 1000 * PAPC_LONG_MS;
	localparam int          PAPC_CNT_W          = 20;

	typedef struct packed {
		logic fw_check_error;
		logic cell_selftest_error;
		logic converter_selftest_error;
		logic acquisition_done;
		logic acquisition_error;
		logic slope_exceeded;
		logic relative_exceeded;
		logic fixed_exceeded;
	} papc_events_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} papc_regreq_t;
endpackage

// ---- design/papc_alert.sv ----
// module: alert pulse configuration, status flags and pulse generator
// Behaviour
// [R1] polarity bit selects active and idle pin level
// [R2] duration bit picks 4 ms or 8 ms
// [R3] firmware check error pulses when enabled
// [R4] either self-test error pulses when enabled
// [R5] acquisition error pulses when enabled
// [R6] data ready pulses when enabled
// [R7] host leaves reserved bits alone
// [R8] slope monitor only when its enable set
// [R9] relative monitor only when its enable set
// [R10] fixed monitor only when its enable set
// [R11] flags clear after transfers if acknowledged
// [R12] slope exceed sets flags and pulses
// [R13] acquisition pulses only after acquisition completes
// [R14] counter times pulse, pin returns idle
// [R15] events during pulse merge, flags recorded
module papc_alert
	import papc_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire papc_regreq_t reg_req,
	input  wire papc_events_t events,
	input  wire logic         spi_transfers_done,
	input  wire logic         host_acknowledge_flag,
	output logic [7:0]        reg_rdata,
	output logic              alert_pin,
	output logic              slope_monitor_active,
	output logic              relative_monitor_active,
	output logic              fixed_monitor_active
);
	logic [7:0]            trig_reg,   trig_next;
	logic [7:0]            pressure_change_config_reg,  pressure_change_config_next;
	logic [7:0]            status_reg, status_next;
	logic [7:0]            rdata_reg,  rdata_next;
	logic                  busy_reg,   busy_next;
	logic [PAPC_CNT_W-1:0] cnt_reg,    cnt_next;
	logic                  pin_reg,    pin_next;
	logic [2:0]            mon_reg,    mon_next;
	logic                  fire;
	logic                  slope_ev;
	logic                  rel_ev;
	logic                  fix_ev;

	// event decode, monitors gated by their enables
	always_comb begin
		slope_ev = events.slope_exceeded & pressure_change_config_reg[PAPC_SLOPE_EN_BIT]; // R8 R12
		rel_ev   = events.relative_exceeded & pressure_change_config_reg[PAPC_REL_EN_BIT]; // R9
		fix_ev   = events.fixed_exceeded & pressure_change_config_reg[PAPC_FIX_EN_BIT]; // R10
		fire = (events.fw_check_error & trig_reg[PAPC_FV_BIT]) // R3
			| ((events.cell_selftest_error | events.converter_selftest_error)
				& trig_reg[PAPC_ST_BIT]) // R4
			| (events.acquisition_done & events.acquisition_error
				& trig_reg[PAPC_ACQERR_BIT]) // R5 R13
			| (events.acquisition_done & trig_reg[PAPC_RDY_BIT]) // R6 R13
			| slope_ev | rel_ev | fix_ev; // R12
	end

	// configuration registers, reserved bits masked
	always_comb begin
		trig_next  = trig_reg;
		pressure_change_config_next = pressure_change_config_reg;
		if (reg_req.wr && reg_req.addr == PAPC_TRIG_ADDR) begin
			trig_next = reg_req.wdata & PAPC_TRIG_WMASK; // R7
		end
		if (reg_req.wr && reg_req.addr == PAPC_PRESSURE_CHANGE_CONFIG_ADDR) begin
			pressure_change_config_next = reg_req.wdata & PAPC_PRESSURE_CHANGE_CONFIG_WMASK; // R7
		end
		mon_next = pressure_change_config_next[2:0]; // R8 R9 R10
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_reg  <= PAPC_TRIG_RESET;
			pressure_change_config_reg <= PAPC_PRESSURE_CHANGE_CONFIG_RESET;
			mon_reg   <= PAPC_PRESSURE_CHANGE_CONFIG_RESET[2:0];
		end else begin
			trig_reg  <= trig_next;
			pressure_change_config_reg <= pressure_change_config_next;
			mon_reg   <= mon_next;
		end
	end

	a_trig_write: assert property (@(posedge clk) disable iff (!rst_n) // R7
		reg_req.wr && reg_req.addr == PAPC_TRIG_ADDR
		|=> trig_reg == ($past(reg_req.wdata) & PAPC_TRIG_WMASK))
		else $error("trigger register write lost");
	a_trig_hold: assert property (@(posedge clk) disable iff (!rst_n) // R1
		!(reg_req.wr && reg_req.addr == PAPC_TRIG_ADDR) |=> $stable(trig_reg))
		else $error("trigger register changed without write");
	a_trig_reserved: assert property (@(posedge clk) disable iff (!rst_n) // R7
		trig_reg[7:6] == 2'h0)
		else $error("trigger reserved bits set");
	a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n) // R8
		reg_req.wr && reg_req.addr == PAPC_PRESSURE_CHANGE_CONFIG_ADDR
		|=> pressure_change_config_reg == ($past(reg_req.wdata) & PAPC_PRESSURE_CHANGE_CONFIG_WMASK))
		else $error("config register write lost");
	a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!(reg_req.wr && reg_req.addr == PAPC_PRESSURE_CHANGE_CONFIG_ADDR) |=> $stable(pressure_change_config_reg))
		else $error("config register changed without write");
	a_cfg_reserved: assert property (@(posedge clk) disable iff (!rst_n) // R7
		pressure_change_config_reg[7:3] == 5'h00)
		else $error("config reserved bits set");
	a_slope_mon: assert property (@(posedge clk) disable iff (!rst_n) // R8
		slope_monitor_active == pressure_change_config_reg[PAPC_SLOPE_EN_BIT])
		else $error("slope monitor output wrong");
	a_rel_mon: assert property (@(posedge clk) disable iff (!rst_n) // R9
		relative_monitor_active == pressure_change_config_reg[PAPC_REL_EN_BIT])
		else $error("relative monitor output wrong");
	a_fix_mon: assert property (@(posedge clk) disable iff (!rst_n) // R10
		fixed_monitor_active == pressure_change_config_reg[PAPC_FIX_EN_BIT])
		else $error("fixed monitor output wrong");

	// status flags: clear first, then sets win
	always_comb begin
		status_next = status_reg;
		if (spi_transfers_done && host_acknowledge_flag) begin
			status_next = PAPC_STATUS_RESET; // R11
		end
		status_next[PAPC_SLOPE_F_BIT] = status_next[PAPC_SLOPE_F_BIT] | slope_ev; // R12
		status_next[PAPC_REL_F_BIT]   = status_next[PAPC_REL_F_BIT] | rel_ev; // R9
		status_next[PAPC_FIX_F_BIT]   = status_next[PAPC_FIX_F_BIT] | fix_ev; // R10
		status_next[PAPC_FW_F_BIT]    = status_next[PAPC_FW_F_BIT]
			| events.fw_check_error; // R3
		status_next[PAPC_CELL_F_BIT]  = status_next[PAPC_CELL_F_BIT]
			| events.cell_selftest_error; // R4
		status_next[PAPC_CONV_F_BIT]  = status_next[PAPC_CONV_F_BIT]
			| events.converter_selftest_error; // R4
		status_next[PAPC_ACQ_F_BIT]   = status_next[PAPC_ACQ_F_BIT]
			| (events.acquisition_done & events.acquisition_error); // R5 R13
		status_next[PAPC_SUM_F_BIT]   = status_next[PAPC_SUM_F_BIT] | fire; // R15
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_reg <= PAPC_STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	a_status_hold: assert property (@(posedge clk) disable iff (!rst_n) // R11
		!(spi_transfers_done && host_acknowledge_flag) && events == '0 |=> $stable(status_reg))
		else $error("status changed without cause");
	a_ack_keep: assert property (@(posedge clk) disable iff (!rst_n) // R11
		spi_transfers_done && !host_acknowledge_flag && events == '0 |=> $stable(status_reg))
		else $error("status cleared without acknowledge");
	a_rel_flag: assert property (@(posedge clk) disable iff (!rst_n) // R9
		rel_ev |=> status_reg[PAPC_REL_F_BIT] && status_reg[PAPC_SUM_F_BIT])
		else $error("relative event not flagged");
	a_fix_flag: assert property (@(posedge clk) disable iff (!rst_n) // R10
		fix_ev |=> status_reg[PAPC_FIX_F_BIT] && status_reg[PAPC_SUM_F_BIT])
		else $error("fixed event not flagged");
	a_rel_gate: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!pressure_change_config_reg[PAPC_REL_EN_BIT] && !status_reg[PAPC_REL_F_BIT] |=> !status_reg[PAPC_REL_F_BIT])
		else $error("relative flag set while disabled");
	a_fix_gate: assert property (@(posedge clk) disable iff (!rst_n) // R10
		!pressure_change_config_reg[PAPC_FIX_EN_BIT] && !status_reg[PAPC_FIX_F_BIT] |=> !status_reg[PAPC_FIX_F_BIT])
		else $error("fixed flag set while disabled");
	a_fw_flag: assert property (@(posedge clk) disable iff (!rst_n) // R3
		events.fw_check_error |=> status_reg[PAPC_FW_F_BIT])
		else $error("firmware error not recorded");
	a_cell_flag: assert property (@(posedge clk) disable iff (!rst_n) // R4
		events.cell_selftest_error |=> status_reg[PAPC_CELL_F_BIT])
		else $error("cell self-test error not recorded");
	a_conv_flag: assert property (@(posedge clk) disable iff (!rst_n) // R4
		events.converter_selftest_error |=> status_reg[PAPC_CONV_F_BIT])
		else $error("converter self-test error not recorded");
	a_acq_flag: assert property (@(posedge clk) disable iff (!rst_n) // R5
		events.acquisition_done && events.acquisition_error |=> status_reg[PAPC_ACQ_F_BIT])
		else $error("acquisition error not recorded");
	a_acq_gate: assert property (@(posedge clk) disable iff (!rst_n) // R13
		!events.acquisition_done && !status_reg[PAPC_ACQ_F_BIT] |=> !status_reg[PAPC_ACQ_F_BIT])
		else $error("acquisition flag set before completion");
	a_sum_gate: assert property (@(posedge clk) disable iff (!rst_n) // R12
		!fire && !status_reg[PAPC_SUM_F_BIT] |=> !status_reg[PAPC_SUM_F_BIT])
		else $error("summary flag set without trigger");

	// read data, held until the next read
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				PAPC_TRIG_ADDR:   rdata_next = trig_reg;
				PAPC_PRESSURE_CHANGE_CONFIG_ADDR:  rdata_next = pressure_change_config_reg;
				PAPC_STATUS_ADDR: rdata_next = status_reg;
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	a_read_status: assert property (@(posedge clk) disable iff (!rst_n) // R11
		reg_req.rd && reg_req.addr == PAPC_STATUS_ADDR |=> reg_rdata == $past(status_reg))
		else $error("status read data wrong");
	a_read_trig: assert property (@(posedge clk) disable iff (!rst_n) // R1
		reg_req.rd && reg_req.addr == PAPC_TRIG_ADDR |=> reg_rdata == $past(trig_reg))
		else $error("trigger read data wrong");
	a_read_cfg: assert property (@(posedge clk) disable iff (!rst_n) // R8
		reg_req.rd && reg_req.addr == PAPC_PRESSURE_CHANGE_CONFIG_ADDR |=> reg_rdata == $past(pressure_change_config_reg))
		else $error("config read data wrong");
	a_read_hold: assert property (@(posedge clk) disable iff (!rst_n) // R11
		!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data changed without read");
	a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n) // R7
		reg_req.rd && reg_req.addr != PAPC_TRIG_ADDR && reg_req.addr != PAPC_PRESSURE_CHANGE_CONFIG_ADDR
		&& reg_req.addr != PAPC_STATUS_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	// pulse timer, new events merge into running pulse
	always_comb begin
		busy_next = busy_reg;
		cnt_next  = cnt_reg;
		if (busy_reg) begin
			if (cnt_reg == PAPC_CNT_W'(1)) begin
				busy_next = 1'b0; // R14
			end
			cnt_next = cnt_reg - PAPC_CNT_W'(1); // R14
		end else if (fire) begin
			busy_next = 1'b1;
			cnt_next  = trig_reg[PAPC_DUR_BIT] ? PAPC_CNT_W'(PAPC_LONG_CYC)
				: PAPC_CNT_W'(PAPC_SHORT_CYC); // R2
		end
		// polarity written this cycle applies on the same edge
		pin_next = busy_next ? trig_next[PAPC_POL_BIT] : ~trig_next[PAPC_POL_BIT]; // R1 R14
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			cnt_reg  <= '0;
			pin_reg  <= ~PAPC_TRIG_RESET[PAPC_POL_BIT];
		end else begin
			busy_reg <= busy_next;
			cnt_reg  <= cnt_next;
			pin_reg  <= pin_next;
		end
	end

	a_cell_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R4
		events.cell_selftest_error && trig_reg[PAPC_ST_BIT] |=> busy_reg)
		else $error("cell self-test error gave no pulse");
	a_no_fire_idle: assert property (@(posedge clk) disable iff (!rst_n) // R3
		!busy_reg && !fire |=> !busy_reg)
		else $error("pulse started without trigger");
	a_count_down: assert property (@(posedge clk) disable iff (!rst_n) // R14
		busy_reg && cnt_reg > PAPC_CNT_W'(1) |=> busy_reg && cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("pulse counter not counting down");
	a_cnt_range: assert property (@(posedge clk) disable iff (!rst_n) // R2
		busy_reg |-> cnt_reg != '0 && cnt_reg <= PAPC_CNT_W'(PAPC_LONG_CYC))
		else $error("pulse counter out of range");
	a_idle_count: assert property (@(posedge clk) disable iff (!rst_n) // R14
		!busy_reg |-> cnt_reg == '0)
		else $error("pulse counter running while idle");

	assign reg_rdata               = rdata_reg;
	assign alert_pin               = pin_reg;
	assign slope_monitor_active    = mon_reg[PAPC_SLOPE_EN_BIT]; // R8
	assign relative_monitor_active = mon_reg[PAPC_REL_EN_BIT]; // R9
	assign fixed_monitor_active    = mon_reg[PAPC_FIX_EN_BIT]; // R10

	// assertions
	a_idle_level: assert property (@(posedge clk) disable iff (!rst_n) // R1
		!busy_reg |-> alert_pin == ~trig_reg[PAPC_POL_BIT])
		else $error("idle pin level wrong");
	a_active_level: assert property (@(posedge clk) disable iff (!rst_n) // R1
		busy_reg |-> alert_pin == trig_reg[PAPC_POL_BIT])
		else $error("active pin level wrong");
	a_pulse_load: assert property (@(posedge clk) disable iff (!rst_n) // R2
		!busy_reg && fire |=> busy_reg && cnt_reg == ($past(trig_reg[PAPC_DUR_BIT])
			? PAPC_CNT_W'(PAPC_LONG_CYC) : PAPC_CNT_W'(PAPC_SHORT_CYC)))
		else $error("pulse length load wrong");
	a_fw_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R3
		events.fw_check_error && trig_reg[PAPC_FV_BIT] |=> busy_reg && status_reg[7])
		else $error("firmware error gave no pulse");
	a_st_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R4
		events.converter_selftest_error && trig_reg[PAPC_ST_BIT] |=> busy_reg)
		else $error("self-test error gave no pulse");
	a_acq_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R5
		events.acquisition_done && events.acquisition_error && trig_reg[PAPC_ACQERR_BIT]
		|=> busy_reg)
		else $error("acquisition error gave no pulse");
	a_rdy_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R6
		events.acquisition_done && trig_reg[PAPC_RDY_BIT] |=> busy_reg)
		else $error("data ready gave no pulse");
	a_slope_flag: assert property (@(posedge clk) disable iff (!rst_n) // R12
		slope_ev |=> status_reg[6] && status_reg[7] && busy_reg)
		else $error("slope event not flagged");
	a_slope_gate: assert property (@(posedge clk) disable iff (!rst_n) // R8
		!pressure_change_config_reg[PAPC_SLOPE_EN_BIT] && !status_reg[6] |=> !status_reg[6])
		else $error("slope flag set while disabled");
	a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n) // R11
		spi_transfers_done && host_acknowledge_flag && !fire && events == '0
		|=> status_reg == 8'h00)
		else $error("status not cleared on acknowledge");
	a_pulse_end: assert property (@(posedge clk) disable iff (!rst_n) // R14
		busy_reg && cnt_reg == PAPC_CNT_W'(1) |=> !busy_reg)
		else $error("pulse did not end");
	a_pulse_merge: assert property (@(posedge clk) disable iff (!rst_n) // R15
		busy_reg && cnt_reg > PAPC_CNT_W'(1) && fire |=> cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("pulse restarted on merged event");

	c_pulse_start: cover property (@(posedge clk) disable iff (!rst_n) !busy_reg ##1 busy_reg);
	c_pulse_end:   cover property (@(posedge clk) disable iff (!rst_n) busy_reg ##1 !busy_reg);
	c_ack_clear:   cover property (@(posedge clk) disable iff (!rst_n)
		status_reg[7] ##1 status_reg == 8'h00);
	c_merge:       cover property (@(posedge clk) disable iff (!rst_n) busy_reg && fire);
	c_idle_high:   cover property (@(posedge clk) disable iff (!rst_n)
		!trig_reg[PAPC_POL_BIT] && !busy_reg);
endmodule // papc_alert

// ---- bench/papc_host_model.sv ----
// host model: register strobes and acknowledge handshake toward the alert block
module papc_host_model
	import papc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic [7:0] rdata,
	output papc_regreq_t req,
	output logic        spi_done,
	output logic        ack
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req = '0;
		spi_done = 1'b0;
		ack = 1'b0;
	end
	task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: w, rd: !w, addr: a,
			wdata: d & ((a == PAPC_TRIG_ADDR) ? PAPC_TRIG_WMASK : PAPC_PRESSURE_CHANGE_CONFIG_WMASK)};
		@(negedge clk);
		req <= '0;
	endtask
	task read(input logic [15:0] a, output logic [7:0] d);
		xfer(1'b0, a, 8'h00);
		d = rdata;
	endtask
	task finish_spi(input logic a);
		@(negedge clk);
		ack <= a;
		spi_done <= 1'b1;
		@(negedge clk);
		spi_done <= 1'b0;
		ack <= 1'b0;
	endtask
endmodule // papc_host_model

// ---- bench/pressure_alert_pulse_config_test.sv ----
// testbench: register access, event triggers, pulse merge and status clear
module pressure_alert_pulse_config_test
	import papc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	papc_regreq_t req;
	papc_events_t ev = '0;
	logic         spi_done, ack, pin, ms, mr, mf;
	logic [7:0]   rdata, d;
	int           bad_count = 0;
	int           checks_done = 0;
	initial forever #5 clk = ~clk;
	papc_host_model i_host (.clk(clk), .rdata(rdata), .req(req), .spi_done(spi_done), .ack(ack));
	papc_alert i_dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .events(ev),
		.spi_transfers_done(spi_done), .host_acknowledge_flag(ack), .reg_rdata(rdata),
		.alert_pin(pin), .slope_monitor_active(ms), .relative_monitor_active(mr),
		.fixed_monitor_active(mf));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task rchk(input string n, input logic [15:0] a, input logic [7:0] e);
		i_host.read(a, d);
		chk(n, e, d);
	endtask
	task fire(input papc_events_t e);
		@(negedge clk);
		ev <= e;
		@(negedge clk);
		ev <= '0;
	endtask
	task stop_test;
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#900us;
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk("pin", 8'h00, {7'h00, pin});
		chk("monitors", 8'h01, {5'h00, ms, mr, mf});
		rchk("trig", PAPC_TRIG_ADDR, 8'h3E);
		rchk("cfg", PAPC_PRESSURE_CHANGE_CONFIG_ADDR, 8'h01);
		rchk("status", PAPC_STATUS_ADDR, 8'h00);
		rchk("unmapped", 16'h0000, 8'h00);
		i_host.xfer(1'b1, PAPC_TRIG_ADDR, 8'h20);
		rchk("trig", PAPC_TRIG_ADDR, 8'h20);
		fire(8'hFC);
		chk("pin", 8'h00, {7'h00, pin});
		rchk("status", PAPC_STATUS_ADDR, 8'h0F);
		i_host.finish_spi(1'b0);
		rchk("status", PAPC_STATUS_ADDR, 8'h0F);
		i_host.finish_spi(1'b1);
		rchk("status", PAPC_STATUS_ADDR, 8'h00);
		i_host.xfer(1'b1, PAPC_PRESSURE_CHANGE_CONFIG_ADDR, 8'h07);
		rchk("cfg", PAPC_PRESSURE_CHANGE_CONFIG_ADDR, 8'h07);
		chk("monitors", 8'h07, {5'h00, ms, mr, mf});
		i_host.xfer(1'b1, PAPC_TRIG_ADDR, 8'h21);
		fire(8'h10);
		chk("pin", 8'h01, {7'h00, pin});
		rchk("status", PAPC_STATUS_ADDR, 8'h80);
		fire(8'h84);
		chk("pin", 8'h01, {7'h00, pin});
		rchk("status", PAPC_STATUS_ADDR, 8'hC8);
		i_host.xfer(1'b1, PAPC_TRIG_ADDR, 8'h01);
		@(negedge clk);
		chk("pin", 8'h00, {7'h00, pin});
		repeat (1000) @(negedge clk);
		chk("pin", 8'h00, {7'h00, pin});
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("pin", 8'h00, {7'h00, pin});
		chk("monitors", 8'h01, {5'h00, ms, mr, mf});
		rchk("trig", PAPC_TRIG_ADDR, 8'h3E);
		i_host.xfer(1'b1, PAPC_TRIG_ADDR, 8'h02);
		chk("pin", 8'h01, {7'h00, pin});
		fire(8'h08);
		chk("pin", 8'h01, {7'h00, pin});
		rchk("status", PAPC_STATUS_ADDR, 8'h00);
		fire(8'h18);
		chk("pin", 8'h00, {7'h00, pin});
		rchk("status", PAPC_STATUS_ADDR, 8'h81);
		stop_test;
	end
endmodule // pressure_alert_pulse_config_test
